// ---- gpext_port.sv ----
/*
 * Eight-pin general purpose port with alternate functions and one
 * grouped external interrupt request, Wishbone classic register slave.
 * Assumes one clock, synchronous reset, pads resolved outside from
 * pin_o / pin_oe_o / pull_up_o, and a CPU that pulses vec_fetch_i
 * when it fetches this interrupt's vector.
 */
// The placing of the registers and register access over Wishbone were decided locally.
// Notes on behaviour
// - An interrupt-input pin raises an external request on the selected event.
// - Each interrupt pin can request; sensitivity comes from misc control bits.
// - Enabled interrupt pins of the group are combined by AND.
// - Request latch is hidden from software; vector fetch clears it.
// - Changing the sensitivity clears a pending request.
// - Output pins drive the value latch; reads return the latch.
// - Value 0 drives low; 1 drives high push-pull, floats open-drain.
// - An enabled peripheral function overrides normal port programming.
// - Peripheral output forces output mode, push-pull or open-drain.
// - Peripheral inputs need input mode; pin stays readable via value.
// - Input pin with peripheral output reads back the peripheral level.
// - Output pin with peripheral input feeds the latch to the peripheral.
// - Standard pins: 00 float, 01 pull-up, 10 open-drain, 11 push-pull.
// - Interrupt pins with pull-up: 01 is pull-up interrupt input.
// - Interrupt pins without pull-up: 01 is floating interrupt input.
// - True open-drain pins: no option; 0 float input, 1 open-drain.
// - Bus transmit pin is a pull-up input only in port role.
// - Low-power states keep port state; enabled interrupt wakes.
// - Input pins read the pin level through a two-flop synchroniser, two clocks late.
// - Writes to the latch of an input pin do not reach the pin.
// - Value, direction and option registers reset to zero.
`timescale 1ns/10ps
`default_nettype none
`include "gpext_consts.svh"

module gpext_port #(
   parameter int unsigned  PORT_W = `GPEXT_PORT_W,
   parameter logic [23:0]  KINDS  = `GPEXT_KINDS_DFLT
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [4:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic [PORT_W-1:0] pin_i,
   output logic      [PORT_W-1:0] pin_o,
   output logic      [PORT_W-1:0] pin_oe_o,
   output logic      [PORT_W-1:0] pull_up_o,
   input  wire logic [PORT_W-1:0] alt_en_i,
   input  wire logic [PORT_W-1:0] alt_drive_i,
   input  wire logic [PORT_W-1:0] alt_pp_i,
   input  wire logic [PORT_W-1:0] alt_out_i,
   output logic      [PORT_W-1:0] alt_in_o,
   input  wire logic              vec_fetch_i,
   output logic                   irq_req_o,
   output logic                   wake_o
);

   // ============================================================
   // State
   typedef struct packed {
      logic [PORT_W-1:0] latch;
      logic [PORT_W-1:0] dir;
      logic [PORT_W-1:0] opt;
      logic [1:0]        sens;
      logic [PORT_W-1:0] sync1;
      logic [PORT_W-1:0] sync2;
      logic              grp_prev;
      logic              grp_any_prev;
      logic              pend;
      logic              ack;
      logic [31:0]       rdat;
      logic [PORT_W-1:0] pin;
      logic [PORT_W-1:0] oe;
      logic [PORT_W-1:0] pu;
      logic [PORT_W-1:0] alt_in;
   } gpext_state_t;

   gpext_state_t st_q;
   gpext_state_t st_d;

   // ============================================================
   // Per-pin decode of the fixed pad variant
   logic [PORT_W-1:0] has_opt;
   logic [PORT_W-1:0] is_int;
   logic [PORT_W-1:0] is_pu_only;
   logic [PORT_W-1:0] dir_eff;
   logic [PORT_W-1:0] pp_eff;
   logic [PORT_W-1:0] int_en;
   logic [PORT_W-1:0] alt_drv;
   logic [PORT_W-1:0] rd_val;
   logic [PORT_W-1:0] pin_n;
   logic [PORT_W-1:0] oe_n;
   logic [PORT_W-1:0] pu_n;
   logic [PORT_W-1:0] ain_n;

   genvar g;
   generate
      for (g = 0; g < PORT_W; g = g + 1) begin : g_pin
         gpext_pkg::gpext_kind_t kind;
         assign kind = gpext_pkg::gpext_kind_t'(KINDS[3*g +: 3]);
         // True open-drain and pull-up-only pins have no option bit
         assign has_opt[g] = (kind != gpext_pkg::GPEXT_TRUE_OD) &&
                             (kind != gpext_pkg::GPEXT_PU_ONLY);
         assign is_int[g] = (kind == gpext_pkg::GPEXT_INT_PU) ||
                            (kind == gpext_pkg::GPEXT_INT_FL);
         assign is_pu_only[g] = (kind == gpext_pkg::GPEXT_PU_ONLY);
         assign dir_eff[g] = st_q.dir[g] & ~is_pu_only[g];
         assign pp_eff[g]  = st_q.opt[g] & has_opt[g];
         // Input with option set on an interrupt pad
         assign int_en[g] = is_int[g] & ~st_q.dir[g] & st_q.opt[g];
         assign alt_drv[g] = alt_en_i[g] & alt_drive_i[g];
         always_comb begin
            if (alt_drv[g]) begin
               // Peripheral owns the pad, push-pull or open-drain
               pin_n[g] = alt_out_i[g] & alt_pp_i[g];
               oe_n[g]  = alt_pp_i[g] | ~alt_out_i[g];
            end else if (dir_eff[g]) begin
               pin_n[g] = st_q.latch[g] & pp_eff[g];
               oe_n[g]  = pp_eff[g] | ~st_q.latch[g];
            end else begin
               pin_n[g] = 1'h0;
               oe_n[g]  = 1'h0;
            end
            pu_n[g] = ~alt_drv[g] & ~dir_eff[g] &
                      (is_pu_only[g] |
                       (pp_eff[g] & (kind != gpext_pkg::GPEXT_INT_FL)));
            // Output pin feeds the latch to a peripheral input
            ain_n[g] = dir_eff[g] ? st_q.latch[g] : st_q.sync2[g];
            if (dir_eff[g]) begin
               rd_val[g] = st_q.latch[g];
            end else if (alt_drv[g]) begin
               rd_val[g] = alt_out_i[g];
            end else begin
               rd_val[g] = st_q.sync2[g];
            end
         end
      end
   endgenerate

   // ============================================================
   // Grouped interrupt: enabled pins ANDed, one request latch
   logic grp_any;
   logic grp_lvl;
   logic ev_fall;
   logic ev_rise;
   logic ev_hit;

   assign grp_any = |int_en;
   assign grp_lvl = &(st_q.sync2 | ~int_en);
   // No edge is seen on the cycle a group first becomes enabled
   assign ev_fall = grp_any & st_q.grp_any_prev & st_q.grp_prev & ~grp_lvl;
   assign ev_rise = grp_any & st_q.grp_any_prev & ~st_q.grp_prev & grp_lvl;

   always_comb begin
      case (gpext_pkg::gpext_sens_t'(st_q.sens))
         gpext_pkg::GPEXT_FALL_LOW: ev_hit = grp_any & ~grp_lvl;
         gpext_pkg::GPEXT_RISE:     ev_hit = ev_rise;
         gpext_pkg::GPEXT_FALL:     ev_hit = ev_fall;
         gpext_pkg::GPEXT_BOTH:     ev_hit = ev_rise | ev_fall;
         default:                   ev_hit = 1'h0;
      endcase
   end

   // ============================================================
   // Wishbone classic slave, one wait state then a one-cycle ack
   logic       req;
   logic       wr;
   logic [7:0] wbyte;
   logic       sens_wr;

   assign req     = wb_cyc_i & wb_stb_i & ~st_q.ack;
   assign wr      = req & wb_we_i & wb_sel_i[0];
   assign wbyte   = wb_dat_i[7:0];
   assign sens_wr = wr && (wb_adr_i == `GPEXT_OFS_SENS);

   always_comb begin
      st_d        = st_q;
      st_d.sync1  = pin_i;
      st_d.sync2  = st_q.sync1;
      st_d.grp_prev     = grp_lvl;
      st_d.grp_any_prev = grp_any;
      st_d.ack    = req;
      st_d.pin    = pin_n;
      st_d.oe     = oe_n;
      st_d.pu     = pu_n;
      st_d.alt_in = ain_n;
      st_d.rdat   = 32'h0;
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            `GPEXT_OFS_VALUE:  st_d.rdat[PORT_W-1:0] = rd_val;
            `GPEXT_OFS_DIR:    st_d.rdat[PORT_W-1:0] = st_q.dir;
            `GPEXT_OFS_OPT:    st_d.rdat[PORT_W-1:0] = st_q.opt;
            `GPEXT_OFS_SENS:   st_d.rdat[1:0] = st_q.sens;
            `GPEXT_OFS_STATUS: st_d.rdat[PORT_W-1:0] = int_en;
            default:           st_d.rdat = 32'h0;
         endcase
      end
      if (wr) begin
         case (wb_adr_i)
            `GPEXT_OFS_VALUE: st_d.latch = wbyte[PORT_W-1:0];
            `GPEXT_OFS_DIR:   st_d.dir = wbyte[PORT_W-1:0] & ~is_pu_only;
            `GPEXT_OFS_OPT:   st_d.opt = wbyte[PORT_W-1:0] & has_opt;
            `GPEXT_OFS_SENS:  st_d.sens = wbyte[1:0];
            default:          st_d.sens = st_q.sens;
         endcase
      end
      // A new event wins over both ways of clearing the latch
      if (vec_fetch_i || sens_wr) begin
         st_d.pend = 1'h0;
      end
      if (ev_hit) begin
         st_d.pend = 1'h1;
      end
      if (rst_i) begin
         st_d = '0;
         st_d.latch = `GPEXT_RST_BYTE;
         st_d.dir   = `GPEXT_RST_BYTE;
         st_d.opt   = `GPEXT_RST_BYTE;
         st_d.sens  = `GPEXT_RST_SENS;
      end
   end

   always_ff @(posedge clk_i) begin
      st_q <= st_d;
   end

   assign wb_dat_o  = st_q.rdat;
   assign wb_ack_o  = st_q.ack;
   assign pin_o     = st_q.pin;
   assign pin_oe_o  = st_q.oe;
   assign pull_up_o = st_q.pu;
   assign alt_in_o  = st_q.alt_in;
   assign irq_req_o = st_q.pend;
   // Port state has no low-power input at all, so stop states leave it
   assign wake_o    = st_q.pend;

   // ============================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   reset_zero_a: assert property ($past(rst_i) |->
      st_q.latch == 8'h00 && st_q.dir == 8'h00 && st_q.opt == 8'h00)
      else $error("port registers not zero after reset");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o)
      else $error("ack not given one cycle after request");
   fetch_clear_a: assert property (vec_fetch_i && !ev_hit |=> !irq_req_o)
      else $error("vector fetch did not clear request");
   sens_clear_a: assert property (sens_wr && !ev_hit |=> !irq_req_o)
      else $error("sensitivity change kept request");
   event_set_a: assert property (ev_hit |=> irq_req_o)
      else $error("event did not raise request");
   and_mask_a: assert property (grp_any && |(int_en & ~st_q.sync2) |->
      !grp_lvl)
      else $error("low pin did not mask group");
   od_drive_a: assert property (!alt_drv[6] && dir_eff[6] &&
      !pp_eff[6] && st_q.latch[6] |=> !pin_oe_o[6])
      else $error("open-drain one drove the pin");
   push_pull_a: assert property (!alt_drv[4] && dir_eff[4] && pp_eff[4]
      |=> pin_oe_o[4] && pin_o[4] == $past(st_q.latch[4]))
      else $error("push-pull output does not follow latch");
   alt_read_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
      !wb_we_i && wb_adr_i == 5'h00 && !dir_eff[5] && alt_drv[5] |=>
      wb_dat_o[5] == $past(alt_out_i[5]))
      else $error("input pin read missed peripheral level");
   in_float_a: assert property (!dir_eff[2] && !alt_drv[2] |=>
      !pin_oe_o[2])
      else $error("input pin was driven");

   irq_seen_c: cover property (ev_hit ##1 irq_req_o ##[1:20] vec_fetch_i);
   write_read_c: cover property (wr ##2 wb_cyc_i && !wb_we_i ##1 wb_ack_o);
   alt_over_c: cover property (alt_drv[0] && dir_eff[0]);
   group_two_c: cover property ($countones(int_en) > 1 && ev_fall);

endmodule : gpext_port
`default_nettype wire

// ---- gpext_consts.svh ----
/*
 * Offsets, field positions, reset values and fixed codes for the
 * eight-pin port with external interrupt.
 * Assumes byte addresses on a 32-bit Wishbone slave, one word per register.
 */
`ifndef GPEXT_CONSTS_SVH
`define GPEXT_CONSTS_SVH

// ============================================================
// Register byte offsets
`define GPEXT_OFS_VALUE   5'h00
`define GPEXT_OFS_DIR     5'h04
`define GPEXT_OFS_OPT     5'h08
`define GPEXT_OFS_SENS    5'h0C
`define GPEXT_OFS_STATUS  5'h10

// ============================================================
// Reset values and fields
`define GPEXT_RST_BYTE    8'h00
`define GPEXT_RST_SENS    2'h0
`define GPEXT_SENS_W      2
`define GPEXT_PORT_W      8
`define GPEXT_KIND_W      3
// Default pin kinds, 3 bits per pin, pin 0 in the low bits:
// pins 0..2 interrupt with pull-up, pin 3 interrupt floating,
// pins 4..5 standard, pins 6..7 true open-drain
`define GPEXT_KINDS_DFLT  24'h6C0449

`endif

// ---- gpext_pkg.sv ----
/*
 * Types shared by the port block: pin kinds and sensitivity codes.
 * Assumes gpext_consts.svh for the widths.
 */
`include "gpext_consts.svh"

package gpext_pkg;

   // ============================================================
   // Fixed pad variant of each pin
   typedef enum logic [2:0] {
      GPEXT_STD     = 3'h0,
      GPEXT_INT_PU  = 3'h1,
      GPEXT_INT_FL  = 3'h2,
      GPEXT_TRUE_OD = 3'h3,
      GPEXT_PU_ONLY = 3'h4
   } gpext_kind_t;

   // ============================================================
   // Interrupt sensitivity held in the misc control bits
   typedef enum logic [1:0] {
      GPEXT_FALL_LOW = 2'h0,
      GPEXT_RISE     = 2'h1,
      GPEXT_FALL     = 2'h2,
      GPEXT_BOTH     = 2'h3
   } gpext_sens_t;

endpackage : gpext_pkg

// ---- gpext_pad_mdl.sv ----
/* Far side of the port: pads, external drivers and pulls.
   Assumes the bench supplies one external driver per pin. */
`timescale 1ns/10ps
`default_nettype none
module gpext_pad_mdl (
   input  wire logic       clk_i,
   input  wire logic [7:0] drv_i,
   input  wire logic [7:0] oe_i,
   input  wire logic [7:0] pu_i,
   input  wire logic [7:0] ext_oe_i,
   input  wire logic [7:0] ext_val_i,
   output logic      [7:0] level_o
);
   logic [7:0] float_q = 8'h00;
   // Undriven unpulled pins wander so nothing can lean on a stale level
   always_ff @(posedge clk_i) float_q <= ~float_q;
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         if (oe_i[n]) level_o[n] = drv_i[n];
         else if (ext_oe_i[n]) level_o[n] = ext_val_i[n];
         else if (pu_i[n]) level_o[n] = 1'b1;
         else level_o[n] = float_q[n];
      end
   end
endmodule : gpext_pad_mdl
`default_nettype wire

// ---- testbench.sv ----
/* Self-checking bench for the port block with random stimulus.
   Assumes gpext_port and the pad model gpext_pad_mdl. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0, rdat, seed = 32'h237E, r;
   logic ack, irq, wake, vf = 1'b0;
   logic [7:0] pin_i, pin_o, oe, pu, alt_in, q, v, d, o, e;
   logic [7:0] al_en = 8'h0, al_drv = 8'h0, al_pp = 8'h0, al_out = 8'h0;
   // Pins held low from outside so the reset read of the value is known
   logic [7:0] ext_oe = 8'hFF, ext_val = 8'h00;
   int error_cnt = 0, total_checks = 0;
   // Pin 7 made the transmit pin so its pull-up-only kind is reached
   gpext_port #(.KINDS(24'h8C0449)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(oe), .pull_up_o(pu),
      .alt_en_i(al_en), .alt_drive_i(al_drv), .alt_pp_i(al_pp),
      .alt_out_i(al_out), .alt_in_o(alt_in), .vec_fetch_i(vf),
      .irq_req_o(irq), .wake_o(wake));
   gpext_pad_mdl pads (.clk_i(clk_i), .drv_i(pin_o), .oe_i(oe), .pu_i(pu),
      .ext_oe_i(ext_oe), .ext_val_i(ext_val), .level_o(pin_i));
   initial forever #2 clk_i = ~clk_i;
   // ============================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic step(input int k);
      repeat (k) @(posedge clk_i);
   endtask : step
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
      total_checks++;
      if (g !== ex) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, ex, g);
      end
   endtask : chk
   // Classic cycle; entered and left just after a rising edge
   task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] dv);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, dv};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
      chk("ack", 8'h01, {7'h0, ack | (n < 40)});
   endtask : xfer
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   initial begin
      step(20000);
      error_cnt++;
      report_and_stop();
   end
   // ============================================================
   // Sequence
   initial begin
      step(2);
      rst_i <= 1'b0;
      step(1);
      for (int i = 0; i < 3; i++) begin
         xfer(0, 5'(4 * i), 8'h0);
         chk("reset reg", 8'h00, q);
      end
      chk("reset oe", 8'h00, oe);
      chk("reset pull", 8'h80, pu);
      xfer(0, 5'h14, 8'h0);
      chk("unmapped", 8'h00, q);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         r = rnd();
         v = r[7:0];
         d = r[15:8] & 8'hF0;
         o = r[23:16] & 8'hF0;
         xfer(1, 5'h00, v);
         xfer(1, 5'h04, d);
         xfer(1, 5'h08, o);
         e = d & ((o & 8'h30) | ~v) & 8'h70;
         chk("oe", e, oe);
         chk("pin drive", v & e, pin_o & e);
         chk("pull", (~d & o & 8'h30) | 8'h80, pu);
         xfer(0, 5'h04, 8'h0);
         chk("dir read", d & 8'h7F, q);
         xfer(0, 5'h08, 8'h0);
         chk("opt read", o & 8'h30, q);
         xfer(0, 5'h00, 8'h0);
         chk("latch read", v & d & 8'h7F, q & d & 8'h7F);
      end
      $display("test outputs done");
      xfer(1, 5'h04, 8'h0);
      xfer(1, 5'h08, 8'h0);
      ext_oe <= 8'hFF;
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         ext_val <= r[7:0];
         step(4);
         xfer(0, 5'h00, 8'h0);
         chk("pin read", r[7:0], q);
      end
      $display("test inputs done");
      ext_val <= 8'h09;
      xfer(1, 5'h08, 8'h08);
      chk("float int pull", 8'h00, pu & 8'h09);
      for (int s = 0; s < 4; s++) begin
         ext_val <= 8'h09;
         step(4);
         xfer(1, 5'h0C, 8'(s));
         step(2);
         chk("irq idle", 8'h00, {7'h0, irq});
         ext_val <= 8'h01;
         step(5);
         chk("irq fall", {7'h0, s != 1}, {7'h0, irq});
         chk("wake", {7'h0, s != 1}, {7'h0, wake});
         xfer(1, 5'h0C, 8'(s));
         step(2);
         chk("irq clear", {7'h0, s == 0}, {7'h0, irq});
         ext_val <= 8'h09;
         step(5);
         chk("irq rise", {7'h0, s != 2}, {7'h0, irq});
         vf <= 1'b1;
         step(1);
         vf <= 1'b0;
         step(2);
         chk("irq fetch", 8'h00, {7'h0, irq});
      end
      xfer(1, 5'h08, 8'h09);
      chk("pull int pull", 8'h01, pu & 8'h09);
      ext_val <= 8'h08;
      step(4);
      xfer(1, 5'h0C, 8'h02);
      step(2);
      ext_val <= 8'h00;
      step(5);
      chk("irq masked", 8'h00, {7'h0, irq});
      ext_val <= 8'h09;
      step(4);
      ext_val <= 8'h08;
      step(5);
      chk("irq group", 8'h01, {7'h0, irq});
      xfer(1, 5'h08, 8'h00);
      xfer(1, 5'h0C, 8'h02);
      $display("test interrupt done");
      ext_oe <= 8'h0F;
      xfer(1, 5'h04, 8'h10);
      xfer(1, 5'h00, 8'h10);
      for (int k = 0; k < 4; k++) begin
         al_en <= 8'h34;
         al_drv <= 8'h20;
         al_pp <= {2'h0, k[1], 5'h0};
         al_out <= {2'h0, k[0], 5'h0};
         ext_val <= {5'h0, k[0], 2'h0};
         step(3);
         e = {2'h0, k[1] | ~k[0], 5'h0};
         chk("alt oe", e, oe & 8'h20);
         chk("alt pin", {2'h0, k[0] & k[1], 5'h0}, pin_o & e);
         xfer(0, 5'h00, 8'h0);
         chk("alt read", {2'h0, k[0], 2'h0, k[0], 2'h0}, q & 8'h24);
         chk("alt in", {3'h0, 1'b1, 1'b0, k[0], 2'h0}, alt_in & 8'h14);
      end
      $display("test alternate done");
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
